// File: verification/flash_guard_chk.sv
module flash_guard_chk (
	// Clock, reset and flash state
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_FLASH_INIT,
	// Interface signals watched
	input wire logic ctl_wr,
	input wire logic [1:0] ctl_rdata,
	input wire logic key_wr,
	input wire logic [7:0] key_wdata,
	input wire logic [1:0] key_state,
	input wire logic mov_wr,
	input wire logic [1:0] mon_cfg,
	input wire logic stall,
	input wire logic err_rst
);
	logic [12:0] run_cnt_ff;
	logic erase_ff;
	// Decoded attempts as the device sees them
	wire key_take = key_wr && !stall && !mov_wr;
	wire op_try = mov_wr && ctl_rdata[0] && !stall;
	wire op_ok = op_try && (mon_cfg == 2'h3) && I_FLASH_INIT;

	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	// Stall length counter, wider than the longest run so it never wraps
	always_ff @(posedge I_CLK) begin
		if (!I_NRST || !stall)
			run_cnt_ff <= 13'h0;
		else
			run_cnt_ff <= run_cnt_ff + 13'h1;
	end

	// Kind of the operation in flight
	always_ff @(posedge I_CLK) begin
		if (!I_NRST)
			erase_ff <= 1'h0;
		else if (op_try)
			erase_ff <= ctl_rdata[1];
	end

	mon_err_a: assert property (op_try && mon_cfg != 2'h3 |=> err_rst)
		else $error("monitor fault without error reset");
	op_start_a: assert property (op_ok && key_state == 2'h2 |=> stall && key_state == 2'h0)
		else $error("operation did not stall and relock");
	op_len_a: assert property ($fell(stall) |-> run_cnt_ff == (erase_ff ? 13'hfa0 : 13'h7d0))
		else $error("operation length wrong");
	early_op_a: assert property (op_ok && key_state < 2'h2 |=> key_state == 2'h3)
		else $error("early operation did not disable");
	dis_sticky_a: assert property (key_state == 2'h3 |=> key_state == 2'h3)
		else $error("disabled state left");
	bad_key_a: assert property (key_take && key_state == 2'h0
		&& key_wdata != flash_guard_pkg::KEY_FIRST |=> key_state == 2'h3)
		else $error("wrong key accepted");
	key_first_a: assert property (key_take && key_state == 2'h0
		&& key_wdata == flash_guard_pkg::KEY_FIRST |=> key_state == 2'h1)
		else $error("first key not seen");
	key_second_a: assert property (key_take && key_state == 2'h1
		&& key_wdata == flash_guard_pkg::KEY_SECOND |=> key_state == 2'h2)
		else $error("second key not seen");
	wen_hold_a: assert property (!ctl_wr |=> $stable(ctl_rdata))
		else $error("control changed without write");
	blocked_op_a: assert property (op_try && key_state == 2'h3 |=> !stall [*3])
		else $error("disabled device ran an operation");
	no_init_a: assert property (op_try && mon_cfg == 2'h3 && !I_FLASH_INIT |=> !stall && $stable(key_state))
		else $error("uninitialized flash accepted a write");

	cov_op_c: cover property ($rose(stall));
	cov_err_c: cover property (err_rst);
	cov_dis_c: cover property (key_state == 2'h3);
endmodule

// File: verification/tb.sv
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, nrst = 1'h0, init = 1'h1;
	logic ctl_wr = 1'h0, key_wr = 1'h0, mov_wr = 1'h0, mon_wr = 1'h0;
	logic [1:0] ctl_data = 2'h0, mon_data = 2'h0, kst, ctl;
	logic [7:0] key_data = 8'h0, mov_data = 8'h0, rd;
	logic [12:0] mov_addr = 13'h0, rd_addr = 13'h0;
	logic refused, stall, flash_err, busy, disabled;
	int failures = 0, compares = 0, mk, mctl, mmon, n;
	int mem_m[int];
	flash_guard_if bus_if();
	flash_core_end u_flash_core_end (.I_CLK(clk), .I_NRST(nrst), .I_CTL_WR(ctl_wr),
		.I_CTL_DATA(ctl_data), .I_KEY_WR(key_wr), .I_KEY_DATA(key_data), .I_MOV_WR(mov_wr),
		.I_MOV_ADDR(mov_addr), .I_MOV_DATA(mov_data), .I_RD_ADDR(rd_addr), .I_MON_WR(mon_wr),
		.I_MON_DATA(mon_data), .O_REFUSED(refused), .O_STALL(stall), .O_RD_DATA(rd),
		.O_FLASH_ERR(flash_err), .O_KEY_STATE(kst), .O_CTL(ctl), .bus(bus_if));
	flash_write_key_guard u_flash_write_key_guard (.I_CLK(clk), .I_NRST(nrst),
		.I_FLASH_INIT(init), .O_BUSY(busy), .O_DISABLED(disabled), .bus(bus_if));
	flash_guard_chk u_flash_guard_chk (.I_CLK(clk), .I_NRST(nrst), .I_FLASH_INIT(init),
		.ctl_wr(bus_if.ctl_wr), .ctl_rdata(bus_if.ctl_rdata), .key_wr(bus_if.key_wr),
		.key_wdata(bus_if.key_wdata), .key_state(bus_if.key_state), .mov_wr(bus_if.mov_wr),
		.mon_cfg(bus_if.mon_cfg), .stall(bus_if.stall), .err_rst(bus_if.err_rst));

	// Free-running system clock
	always #5 clk = ~clk;

	task give_verdict;
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One request (0 control, 1 key, 2 move write, 3 monitor), model update and checks
	task req(input int k, input logic [12:0] a, input logic [7:0] d);
		int cyc;
		int err;
		cyc = 0;
		err = 0;
		@(posedge clk);
		case (k)
			0: begin ctl_wr <= 1'h1; ctl_data <= d[1:0]; mctl = d[1:0]; end
			1: begin key_wr <= 1'h1; key_data <= d;
				mk = (mk == 0 && d == 8'ha5) ? 1 : (mk == 1 && d == 8'hf1) ? 2 : 3; end
			2: begin mov_wr <= 1'h1; mov_addr <= a; mov_data <= d; end
			default: begin mon_wr <= 1'h1; mon_data <= d[1:0]; mmon = d[1:0]; end
		endcase
		// Model of an attempted operation; a wrong attempt never reaches the array
		if (k == 2 && mctl[0]) begin
			if (mmon != 3) begin err = 1; mk = (mk == 3) ? 3 : 0; end
			else if (init && mk == 2) begin
				mk = 0;
				cyc = mctl[1] ? 4000 : 2000;
				if (mctl[1])
					for (int i = 0; i < 512; i++) mem_m[int'({a[12:9], 9'h0}) + i] = 255;
				else
					mem_m[a] = mem_m[a] & d;
			end else if (init) mk = 3;
		end
		@(posedge clk);
		{ctl_wr, key_wr, mov_wr, mon_wr} <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(flash_err, err != 0)
		`CHK(stall, cyc != 0)
		`CHK(busy, cyc != 0)
		`CHK(kst, mk)
		`CHK(ctl, mctl)
		`CHK(disabled, mk == 3)
		`CHK(refused, 1'h0)
		n = 0;
		while (stall === 1'h1 && n < 5000) begin @(posedge clk); #1; n++; end
		`CHK(n, cyc)
	endtask

	task rd_chk(input logic [12:0] a);
		@(posedge clk);
		rd_addr <= a;
		repeat (4) @(posedge clk);
		#1;
		`CHK(rd, mem_m[a])
	endtask

	task unlock;
		req(1, 13'h0, 8'ha5);
		req(1, 13'h0, 8'hf1);
	endtask

	task do_reset;
		@(posedge clk);
		nrst <= 1'h0;
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		mk = 0;
		mctl = 0;
		mmon = 0;
	endtask

	// Main sequence
	initial begin
		logic [12:0] a;
		void'($urandom(35));
		do_reset;
		@(posedge clk);
		#1;
		`CHK(kst, 2'h0)
		// Monitor off: attempt ends in an error reset
		req(0, 13'h0, 8'h01);
		unlock;
		req(2, 13'h0, 8'h00);
		// Monitor on but not a reset source is still a fault
		req(3, 13'h0, 8'h01);
		unlock;
		req(2, 13'h0, 8'h00);
		req(3, 13'h0, 8'h03);
		// Erase one page, then two writes to one byte that can only clear bits
		a = 13'($urandom_range(8191));
		req(0, 13'h0, 8'h03);
		unlock;
		req(2, a, 8'h00);
		rd_chk({a[12:9], 9'h0});
		rd_chk({a[12:9], 9'h1ff});
		a = {a[12:9], 9'($urandom)};
		req(0, 13'h0, 8'h01);
		for (int i = 0; i < 2; i++) begin
			unlock;
			req(2, a, 8'($urandom));
			rd_chk(a);
		end
		// Enable off: move write misses flash and leaves the key open
		unlock;
		req(0, 13'h0, 8'h00);
		req(2, a, 8'h00);
		rd_chk(a);
		@(posedge clk);
		init <= 1'h0;
		req(0, 13'h0, 8'h01);
		req(2, a, 8'h00);
		@(posedge clk);
		init <= 1'h1;
		req(2, a, 8'h00);
		rd_chk(a);
		// Wrong key, keys out of order, write before unlock
		for (int k = 0; k < 3; k++) begin
			do_reset;
			req(3, 13'h0, 8'h03);
			req(0, 13'h0, 8'h01);
			if (k == 0) req(1, 13'h0, 8'h5a);
			else if (k == 1) req(1, 13'h0, 8'hf1);
			else req(2, a, 8'h00);
			unlock;
			req(2, a, 8'h00);
			rd_chk(a);
			// A monitor fault must not lift the disabled state
			if (k == 2) begin
				req(3, 13'h0, 8'h00);
				req(2, a, 8'h00);
			end
		end
		// Back-to-back requests: the second falls in the spacing gap and is dropped
		@(posedge clk);
		key_wr <= 1'h1;
		key_data <= 8'ha5;
		@(posedge clk);
		key_wr <= 1'h0;
		ctl_wr <= 1'h1;
		ctl_data <= 2'h0;
		@(posedge clk);
		ctl_wr <= 1'h0;
		#1;
		`CHK(refused, 1'h1)
		repeat (3) @(posedge clk);
		#1;
		`CHK(ctl, mctl)
		`CHK(kst, mk)
		give_verdict;
	end

	// Watchdog at about three times the expected run of some 10300 cycles
	initial begin
		#300000;
		failures++;
		give_verdict;
	end
endmodule

// File: verilog/flash_core_end.sv
module flash_core_end (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	// User requests
	input wire logic I_CTL_WR,
	input wire logic [1:0] I_CTL_DATA,
	input wire logic I_KEY_WR,
	input wire logic [7:0] I_KEY_DATA,
	input wire logic I_MOV_WR,
	input wire logic [12:0] I_MOV_ADDR,
	input wire logic [7:0] I_MOV_DATA,
	input wire logic [12:0] I_RD_ADDR,
	input wire logic I_MON_WR,
	input wire logic [1:0] I_MON_DATA,
	// User answers
	output logic O_REFUSED,
	output logic O_STALL,
	output logic [7:0] O_RD_DATA,
	output logic O_FLASH_ERR,
	output logic [1:0] O_KEY_STATE,
	output logic [1:0] O_CTL,
	// Link to the flash guard
	flash_guard_if.core bus
);
	logic ctl_wr_ff;
	logic [1:0] ctl_wdata_ff;
	logic key_wr_ff;
	logic [7:0] key_wdata_ff;
	logic mov_wr_ff;
	logic [12:0] mov_addr_ff;
	logic [7:0] mov_data_ff;
	logic [12:0] rd_addr_ff;
	logic [1:0] mon_ff;
	logic refused_ff;
	logic stall_ff;
	logic [7:0] rd_data_ff;
	logic err_ff;
	logic [1:0] key_state_ff;
	logic [1:0] ctl_ff;

	wire logic any_req;
	wire logic issued;
	wire logic can_issue;
	wire logic nxt_ctl_wr;
	wire logic nxt_key_wr;
	wire logic nxt_mov_wr;

	// One request per two cycles, since the device raises stall a cycle late
	assign any_req = I_CTL_WR | I_KEY_WR | I_MOV_WR;
	assign issued = ctl_wr_ff | key_wr_ff | mov_wr_ff;
	assign can_issue = ~bus.stall & ~issued;
	// Move writes take priority over key writes, and key writes over control writes
	assign nxt_mov_wr = I_MOV_WR & can_issue;
	assign nxt_key_wr = I_KEY_WR & ~I_MOV_WR & can_issue;
	assign nxt_ctl_wr = I_CTL_WR & ~I_MOV_WR & ~I_KEY_WR & can_issue;

	// Request strobes and the refused flag
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			ctl_wr_ff <= 1'b0;
			key_wr_ff <= 1'b0;
			mov_wr_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			ctl_wr_ff <= nxt_ctl_wr;
			key_wr_ff <= nxt_key_wr;
			mov_wr_ff <= nxt_mov_wr;
			refused_ff <= any_req & ~can_issue;
		end
	end

	// Operand capture; the two monitor bits go out in one write, no gap
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			ctl_wdata_ff <= flash_guard_pkg::CTL_RESET;
			key_wdata_ff <= 8'h00;
			mov_addr_ff <= 13'h0000;
			mov_data_ff <= 8'h00;
			rd_addr_ff <= 13'h0000;
			mon_ff <= flash_guard_pkg::MON_RESET;
		end else begin
			ctl_wdata_ff <= I_CTL_DATA;
			key_wdata_ff <= I_KEY_DATA;
			mov_addr_ff <= I_MOV_ADDR;
			mov_data_ff <= I_MOV_DATA;
			rd_addr_ff <= I_RD_ADDR;
			if (I_MON_WR) begin
				mon_ff <= I_MON_DATA;
			end
		end
	end

	// Answers back to the user
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			stall_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			err_ff <= 1'b0;
			key_state_ff <= 2'h0;
			ctl_ff <= flash_guard_pkg::CTL_RESET;
		end else begin
			stall_ff <= bus.stall;
			rd_data_ff <= bus.rd_data;
			err_ff <= bus.err_rst;
			key_state_ff <= bus.key_state;
			ctl_ff <= bus.ctl_rdata;
		end
	end

	assign bus.ctl_wr = ctl_wr_ff;
	assign bus.ctl_wdata = ctl_wdata_ff;
	assign bus.key_wr = key_wr_ff;
	assign bus.key_wdata = key_wdata_ff;
	assign bus.mov_wr = mov_wr_ff;
	assign bus.mov_addr = mov_addr_ff;
	assign bus.mov_data = mov_data_ff;
	assign bus.rd_addr = rd_addr_ff;
	assign bus.mon_cfg = mon_ff;
	assign O_REFUSED = refused_ff;
	assign O_STALL = stall_ff;
	assign O_RD_DATA = rd_data_ff;
	assign O_FLASH_ERR = err_ff;
	assign O_KEY_STATE = key_state_ff;
	assign O_CTL = ctl_ff;
endmodule

// File: verilog/flash_guard_if.sv
interface flash_guard_if;
	// Program-store control write
	logic ctl_wr;
	logic [1:0] ctl_wdata;
	logic [1:0] ctl_rdata;
	// Key register write and readback
	logic key_wr;
	logic [7:0] key_wdata;
	logic [1:0] key_state;
	// External-move write
	logic mov_wr;
	logic [12:0] mov_addr;
	logic [7:0] mov_data;
	// Code read port
	logic [12:0] rd_addr;
	logic [7:0] rd_data;
	// Supply monitor configuration
	logic [1:0] mon_cfg;
	// Device answers
	logic stall;
	logic err_rst;

	modport dev (
		input ctl_wr, ctl_wdata, key_wr, key_wdata, mov_wr, mov_addr, mov_data,
		input rd_addr, mon_cfg,
		output ctl_rdata, key_state, rd_data, stall, err_rst
	);

	modport core (
		output ctl_wr, ctl_wdata, key_wr, key_wdata, mov_wr, mov_addr, mov_data,
		output rd_addr, mon_cfg,
		input ctl_rdata, key_state, rd_data, stall, err_rst
	);
endinterface

// File: verilog/flash_guard_pkg.sv
package flash_guard_pkg;

	// Geometry of the program store
	localparam int ADDR_W = 13;
	localparam int FLASH_BYTES = 8192;
	localparam int PAGE_W = 9;
	localparam int PAGE_BYTES = 512;

	// Unlock codes and the value of an erased byte
	localparam logic [7:0] KEY_FIRST = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Program-store control field positions and reset values
	localparam int CTL_W = 2;
	localparam int CTL_WRITE_EN_BIT = 0;
	localparam int CTL_ERASE_EN_BIT = 1;
	localparam logic [1:0] CTL_RESET = 2'h0;

	// Supply monitor field positions
	localparam int MON_ENABLE_BIT = 0;
	localparam int MON_RESET_SRC_BIT = 1;
	localparam logic [1:0] MON_RESET = 2'h0;

	// Operation timing, times in ns with the clock period
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 40000;
	localparam int TIMER_W = 12;
	localparam logic [TIMER_W-1:0] WRITE_CYCLES =
		TIMER_W'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] ERASE_CYCLES =
		TIMER_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Lock states of the key check
	typedef enum logic [1:0] {
		KEY_LOCKED,
		KEY_FIRST_SEEN,
		KEY_UNLOCKED,
		KEY_DISABLED
	} key_state_type;

endpackage

// File: verilog/flash_write_key_guard.sv
// Function
// - Write only clears bits; erase sets 0xFF
// - Hardware times every write and erase
// - Stall execution for whole operation
// - Write enable routes move writes to flash
// - Write enable cleared only by software
// - Unlock by 0xA5 then 0xF1, any gap
// - Wrong or misordered key disables until reset
// - Operation before unlock disables until reset
// - Relock after each operation; rekey each time
// - Operation without supply monitor forces error reset
// - Software sets enable and key first
// - Software enables monitor and reset source together
// - Uninitialized flash refuses the software path
module flash_write_key_guard (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	// Flash has been initialized by the debug programmer
	input wire logic I_FLASH_INIT,
	// Status
	output logic O_BUSY,
	output logic O_DISABLED,
	// Link to the core
	flash_guard_if.dev bus
);
	localparam int AW = flash_guard_pkg::ADDR_W;
	localparam int PW = flash_guard_pkg::PAGE_W;
	localparam int TW = flash_guard_pkg::TIMER_W;

	// Program store; not reset, it is non-volatile
	logic [7:0] mem [flash_guard_pkg::FLASH_BYTES];

	flash_guard_pkg::key_state_type key_ff;
	flash_guard_pkg::key_state_type nxt_key;
	logic write_en_ff;
	logic erase_en_ff;
	logic busy_ff;
	logic erasing_ff;
	logic [TW-1:0] cnt_ff;
	logic [AW-PW-1:0] page_ff;
	logic err_ff;
	logic disabled_ff;
	logic [7:0] rd_data_ff;

	wire logic mon_ok;
	wire logic op_try;
	wire logic op_start;
	wire logic op_error;
	wire logic op_blocked;
	wire logic op_done;
	wire logic key_try;
	wire logic erase_step;
	wire logic mem_we;
	wire logic [AW-1:0] mem_wa;
	wire logic [7:0] mem_wd;

	// Key check for one written value in a given state
	function automatic flash_guard_pkg::key_state_type key_step(
		input flash_guard_pkg::key_state_type cur,
		input logic [7:0] val
	);
		case (cur)
			flash_guard_pkg::KEY_LOCKED: begin
				key_step = (val == flash_guard_pkg::KEY_FIRST) ?
					flash_guard_pkg::KEY_FIRST_SEEN : flash_guard_pkg::KEY_DISABLED;
			end
			flash_guard_pkg::KEY_FIRST_SEEN: begin
				key_step = (val == flash_guard_pkg::KEY_SECOND) ?
					flash_guard_pkg::KEY_UNLOCKED : flash_guard_pkg::KEY_DISABLED;
			end
			default: begin
				// A third key, or any key once disabled, leaves it disabled
				key_step = flash_guard_pkg::KEY_DISABLED;
			end
		endcase
	endfunction

	// The monitor must be on and also be a reset source
	assign mon_ok = bus.mon_cfg[flash_guard_pkg::MON_ENABLE_BIT] &
		bus.mon_cfg[flash_guard_pkg::MON_RESET_SRC_BIT];

	// A move write targets flash only while the write enable is set
	assign op_try = bus.mov_wr & write_en_ff & ~busy_ff;
	assign op_error = op_try & ~mon_ok;
	// Without an initialized image a move write with the monitor ready does nothing
	assign op_blocked = op_try & mon_ok & ~I_FLASH_INIT;
	assign op_start = op_try & mon_ok & I_FLASH_INIT &
		(key_ff == flash_guard_pkg::KEY_UNLOCKED);
	assign key_try = bus.key_wr & ~busy_ff & ~bus.mov_wr;

	// Timer end; software never polls, the stall drops by itself
	assign op_done = busy_ff & (cnt_ff == '0);

	// Erase sweeps the page one byte per cycle in the last timer cycles
	assign erase_step = busy_ff & erasing_ff &
		(cnt_ff < TW'(flash_guard_pkg::PAGE_BYTES));
	assign mem_we = (op_start & ~erase_en_ff) | erase_step;
	assign mem_wa = erase_step ? {page_ff, cnt_ff[PW-1:0]} : bus.mov_addr;
	// A write can only pull bits low; erase brings them back to ones
	assign mem_wd = erase_step ? flash_guard_pkg::ERASED_BYTE :
		(mem[bus.mov_addr] & bus.mov_data);

	// Next key state, operation attempts take precedence over key writes
	always_comb begin
		nxt_key = key_ff;
		if (op_error) begin
			// Relock ahead of the forced reset, but a disabled guard stays disabled
			nxt_key = (key_ff == flash_guard_pkg::KEY_DISABLED) ?
				flash_guard_pkg::KEY_DISABLED : flash_guard_pkg::KEY_LOCKED;
		end else if (op_start) begin
			nxt_key = flash_guard_pkg::KEY_LOCKED;
		end else if (op_try & ~op_blocked) begin
			nxt_key = flash_guard_pkg::KEY_DISABLED;
		end else if (key_try) begin
			nxt_key = key_step(key_ff, bus.key_wdata);
		end
	end

	// Key state machine; disabled is left only through reset
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			key_ff <= flash_guard_pkg::KEY_LOCKED;
		end else begin
			key_ff <= nxt_key;
		end
	end

	// Control bits change only on an explicit control write
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			write_en_ff <= flash_guard_pkg::CTL_RESET[flash_guard_pkg::CTL_WRITE_EN_BIT];
			erase_en_ff <= flash_guard_pkg::CTL_RESET[flash_guard_pkg::CTL_ERASE_EN_BIT];
		end else if (bus.ctl_wr & ~busy_ff) begin
			write_en_ff <= bus.ctl_wdata[flash_guard_pkg::CTL_WRITE_EN_BIT];
			erase_en_ff <= bus.ctl_wdata[flash_guard_pkg::CTL_ERASE_EN_BIT];
		end
	end

	// Operation timer and stall
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			busy_ff <= 1'b0;
			erasing_ff <= 1'b0;
			cnt_ff <= '0;
			page_ff <= '0;
		end else if (op_start) begin
			busy_ff <= 1'b1;
			erasing_ff <= erase_en_ff;
			page_ff <= bus.mov_addr[AW-1:PW];
			cnt_ff <= erase_en_ff ? (flash_guard_pkg::ERASE_CYCLES - 1'b1) :
				(flash_guard_pkg::WRITE_CYCLES - 1'b1);
		end else if (op_done) begin
			busy_ff <= 1'b0;
			erasing_ff <= 1'b0;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// Array write port; start and erase sweep never coincide
	always_ff @(posedge I_CLK) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Code read port and flags
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			rd_data_ff <= 8'h00;
			err_ff <= 1'b0;
			disabled_ff <= 1'b0;
		end else begin
			rd_data_ff <= mem[bus.rd_addr];
			err_ff <= op_error;
			disabled_ff <= (nxt_key == flash_guard_pkg::KEY_DISABLED);
		end
	end

	assign bus.stall = busy_ff;
	assign bus.err_rst = err_ff;
	assign bus.rd_data = rd_data_ff;
	assign bus.key_state = key_ff;
	assign bus.ctl_rdata = {erase_en_ff, write_en_ff};
	assign O_BUSY = busy_ff;
	assign O_DISABLED = disabled_ff;
endmodule
